// ---- hw/pfc_cfg.svh ----
// constants for the interleaved boost power factor controller
// assumes a 100 MHz control clock and q15 fixed point samples
`ifndef PFC_CFG_SVH
`define PFC_CFG_SVH

// control clock rate in hz
`define CLK_HZ          100000000
// switching, averaging and loop execution rates in hz
`define SW_HZ           100000
`define AVG_HZ          100000
`define CUR_HZ          50000
`define FF_HZ           50000
`define VLOOP_HZ        2000
`define BAL_HZ          2000
// cycle counts derived from the rates
`define SW_CYCLES       (`CLK_HZ / `SW_HZ)
`define AVG_CYCLES      (`CLK_HZ / `AVG_HZ)
`define CUR_CYCLES      (`CLK_HZ / `CUR_HZ)
`define FF_CYCLES       (`CLK_HZ / `FF_HZ)
`define VLOOP_CYCLES    (`CLK_HZ / `VLOOP_HZ)
`define BAL_CYCLES      (`CLK_HZ / `BAL_HZ)
// tuning targets the gains at the gain ports are derived for
`define VLOOP_BW_HZ     10
`define ILOOP_BW_HZ     4000
`define VLOOP_IBW_DHZ   25
`define ILOOP_IBW_HZ    1000
// fixed point layout
`define GAIN_FRAC       12
`define Q15_FRAC        15
`define Q15_ONE         16'sh7fff
`define Q15_NEG_ONE     -16'sh7fff
`define HALF_PI_Q15     34'sh0000c910
`define AVG_SHIFT       6
`define BAL_LIMIT       16'sh0ccd
`define CNT_W           16

`endif

// ---- hw/pfc_pkg.sv ----
// types and saturation helper shared by the controller files
// assumes pfc_cfg.svh is on the include path
package pfc_pkg;
   typedef logic signed [15:0] q15_t;   // q15 sample or duty
   typedef logic signed [15:0] gain_t;  // gain, 12 fraction bits
   typedef logic signed [33:0] wide_t;  // headroom for products and sums

   // clamp a wide value into [lo, hi]
   function automatic q15_t sat_q15(input wide_t v, input wide_t lo, input wide_t hi);
      if (v > hi)
         return hi[15:0];
      else if (v < lo)
         return lo[15:0];
      else
         return v[15:0];
   endfunction : sat_q15
endpackage : pfc_pkg

// ---- hw/pi_if.sv ----
// signals between the controller and one proportional-integral stage
// assumes all users run on clk_sys
`timescale 1ns/100ps
`default_nettype none
interface pi_if;
   import pfc_pkg::*;
   logic  step;  // one-cycle execute strobe
   q15_t  err;   // setpoint minus feedback
   gain_t kp;    // proportional gain
   gain_t ki;    // integral gain per step
   q15_t  out;   // registered regulator output
   modport regulator (input step, input err, input kp, input ki, output out);
   modport user      (output step, output err, output kp, output ki, input out);
endinterface : pi_if
`default_nettype wire

// ---- hw/pi_regulator.sv ----
// one saturating proportional-integral stage with integrator freeze
// assumes step, err and gains come from logic on clk_sys
`timescale 1ns/100ps
`default_nettype none
`include "pfc_cfg.svh"
module pi_regulator #(
   parameter pfc_pkg::q15_t LO = `Q15_NEG_ONE,  // lowest output
   parameter pfc_pkg::q15_t HI = `Q15_ONE       // highest output
) (
   input  wire logic clk_sys,
   input  wire logic reset,
   pi_if.regulator   p
);
   import pfc_pkg::*;

   q15_t  integ;       // integral accumulator
   q15_t  next_integ;  // accumulator after this step
   q15_t  next_out;    // output after this step
   wide_t prop;        // proportional term
   wide_t cand;        // accumulator candidate before clamp
   q15_t  cand_sat;    // clamped candidate
   wide_t total;       // proportional plus integral
   logic  clamp;       // output would leave its range

   // compute the next output and accumulator
   always_comb
   begin
      prop       = (wide_t'(p.kp) * wide_t'(p.err)) >>> `GAIN_FRAC;
      cand       = wide_t'(integ) + ((wide_t'(p.ki) * wide_t'(p.err)) >>> `GAIN_FRAC);
      cand_sat   = sat_q15(cand, wide_t'(LO), wide_t'(HI));
      total      = prop + wide_t'(cand_sat);
      clamp      = (total > wide_t'(HI)) || (total < wide_t'(LO));
      next_out   = p.out;
      next_integ = integ;
      if (p.step)
      begin
         next_out = sat_q15(total, wide_t'(LO), wide_t'(HI));  // see [R16]
         // hold the accumulator while clamped
         if (!clamp)
            next_integ = cand_sat;  // see [R16]
      end
   end

   // register output and accumulator
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         integ <= '0;
         p.out <= '0;
      end
      else
      begin
         integ <= next_integ;
         p.out <= next_out;
      end
   end

   // output never leaves its range
   property p_out_range;
      @(posedge clk_sys) disable iff (reset)
      (p.out >= LO) && (p.out <= HI);
   endproperty
   a_out_range: assert property (p_out_range) else $error("regulator output out of range"); // see [R16]

   // accumulator frozen on a clamped step
   property p_integ_freeze;
      @(posedge clk_sys) disable iff (reset)
      (p.step && clamp) |=> $stable(integ);
   endproperty
   a_integ_freeze: assert property (p_integ_freeze) else $error("integrator moved while clamped"); // see [R16]
endmodule : pi_regulator
`default_nettype wire

// ---- hw/pfc_control.sv ----
// two phase interleaved boost power factor controller, top level
// assumes samples and gains come from logic on clk_sys, samples q15 scaled, gains with 12 fraction bits
// Operation
// [R1] voltage loop: setpoint minus bus sets amplitude
// [R2] voltage loop runs at 2 kHz
// [R3] current loop: reference minus line current
// [R4] current loop 50 kHz, switching 100 kHz
// [R5] balance loop drives switch current difference zero
// [R6] phase duties: main plus, minus correction
// [R7] balance loop runs at 2 kHz
// [R8] decoupling computed at 50 kHz
// [R9] line voltage average updated at 100 kHz
// [R10] integral gains sized for 2.5 Hz, 1 kHz
// [R11] reference shaped by measured line voltage
// [R12] conduction time varied in fixed period
// [R13] duty compensates line voltage variation
// [R14] two phases offset by half period
// [R15] main duty: one minus (line - inductor)/bus
// [R16] outputs saturated, integrators freeze when clamped
`timescale 1ns/100ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_control #(
   parameter int VOLT_CYCLES = `VLOOP_CYCLES,  // voltage loop period
   parameter int BAL_CYCLES  = `BAL_CYCLES     // balance loop period
) (
   input  wire logic      clk_sys,
   input  wire logic      reset,
   input  wire pfc_pkg::q15_t  bus_voltage_setpoint,
   input  wire pfc_pkg::q15_t  bus_voltage_sample,
   input  wire pfc_pkg::q15_t  line_current_sample,
   input  wire pfc_pkg::q15_t  rectified_line_voltage,
   input  wire pfc_pkg::q15_t  switch_one_current,
   input  wire pfc_pkg::q15_t  switch_two_current,
   input  wire pfc_pkg::gain_t volt_kp,
   input  wire pfc_pkg::gain_t volt_ki,
   input  wire pfc_pkg::gain_t cur_kp,
   input  wire pfc_pkg::gain_t cur_ki,
   input  wire pfc_pkg::gain_t bal_kp,
   input  wire pfc_pkg::gain_t bal_ki,
   output var  pfc_pkg::q15_t  line_current_reference,
   output var  pfc_pkg::q15_t  duty_one,
   output var  pfc_pkg::q15_t  duty_two,
   output var  logic      pwm_one,
   output var  logic      pwm_two
);
   import pfc_pkg::*;

   localparam logic [`CNT_W-1:0] SW_LAST   = `CNT_W'(`SW_CYCLES - 1);
   localparam logic [`CNT_W-1:0] SW_HALF   = `CNT_W'(`SW_CYCLES / 2);
   localparam logic [`CNT_W-1:0] CUR_LAST  = `CNT_W'(`CUR_CYCLES - 1);
   localparam logic [`CNT_W-1:0] VOLT_LAST = `CNT_W'(VOLT_CYCLES - 1);
   localparam logic [`CNT_W-1:0] BAL_LAST  = `CNT_W'(BAL_CYCLES - 1);

   // rate timers
   logic [`CNT_W-1:0] sw_cnt, next_sw_cnt;      // switching period position
   logic [`CNT_W-1:0] cur_cnt, next_cur_cnt;    // current loop timer
   logic [`CNT_W-1:0] volt_cnt, next_volt_cnt;  // voltage loop timer
   logic [`CNT_W-1:0] bal_cnt, next_bal_cnt;    // balance loop timer
   logic              avg_step;                 // average update strobe
   logic              cur_step;                 // current loop strobe
   logic              volt_step;                // voltage loop strobe
   logic              bal_step;                 // balance loop strobe

   // pipeline and arithmetic state
   logic  dec_step, split_step;        // delayed strobes after current step
   q15_t  vavg, next_vavg;             // averaged rectified line voltage
   q15_t  next_iref;                   // next current reference
   q15_t  duty_main, next_main;        // main duty
   q15_t  next_duty_one, next_duty_two;
   q15_t  on_one, on_two;              // latched on-times in cycles
   q15_t  next_on_one, next_on_two;
   logic [`CNT_W-1:0] ph_two;          // phase two position
   logic  next_pwm_one, next_pwm_two;
   wide_t vm;                          // estimated line peak
   wide_t shape_num;                   // amplitude times line voltage
   wide_t drop;                        // line minus inductor voltage, scaled

   pi_if volt_if ();
   pi_if cur_if ();
   pi_if bal_if ();

   // timer next values and strobes
   always_comb
   begin
      avg_step      = (sw_cnt == '0);   // see [R9]
      cur_step      = (cur_cnt == '0);  // see [R4]
      volt_step     = (volt_cnt == '0); // see [R2]
      bal_step      = (bal_cnt == '0);  // see [R7]
      next_sw_cnt   = (sw_cnt == SW_LAST) ? '0 : sw_cnt + 1'b1;
      next_cur_cnt  = (cur_cnt == CUR_LAST) ? '0 : cur_cnt + 1'b1;
      next_volt_cnt = (volt_cnt == VOLT_LAST) ? '0 : volt_cnt + 1'b1;
      next_bal_cnt  = (bal_cnt == BAL_LAST) ? '0 : bal_cnt + 1'b1;
   end

   // timer registers
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         sw_cnt   <= '0;
         cur_cnt  <= '0;
         volt_cnt <= '0;
         bal_cnt  <= '0;
      end
      else
      begin
         sw_cnt   <= next_sw_cnt;
         cur_cnt  <= next_cur_cnt;
         volt_cnt <= next_volt_cnt;
         bal_cnt  <= next_bal_cnt;
      end
   end

   // regulator hookup
   assign volt_if.step = volt_step;
   assign volt_if.err  = q15_t'(bus_voltage_setpoint - bus_voltage_sample);  // see [R1]
   assign volt_if.kp   = volt_kp;
   assign volt_if.ki   = volt_ki;  // see [R10]
   assign cur_if.step  = cur_step;
   assign cur_if.err   = q15_t'(line_current_reference - line_current_sample);  // see [R3]
   assign cur_if.kp    = cur_kp;
   assign cur_if.ki    = cur_ki;  // see [R10]
   assign bal_if.step  = bal_step;
   // zero setpoint minus the feedback (one minus two), so a heavier phase one backs off
   assign bal_if.err   = q15_t'(switch_two_current - switch_one_current);  // see [R5]
   assign bal_if.kp    = bal_kp;
   assign bal_if.ki    = bal_ki;

   // outer loop: amplitude is never negative
   pi_regulator #(.LO(16'sh0000), .HI(`Q15_ONE)) u_volt (
      .clk_sys (clk_sys),
      .reset   (reset),
      .p       (volt_if.regulator)
   );
   // inner loop: output is the inductor voltage command
   pi_regulator #(.LO(`Q15_NEG_ONE), .HI(`Q15_ONE)) u_cur (
      .clk_sys (clk_sys),
      .reset   (reset),
      .p       (cur_if.regulator)
   );
   // balance loop: small symmetric correction
   pi_regulator #(.LO(-`BAL_LIMIT), .HI(`BAL_LIMIT)) u_bal (
      .clk_sys (clk_sys),
      .reset   (reset),
      .p       (bal_if.regulator)
   );

   // averaging, reference shaping, decoupling, split and pwm next values
   always_comb
   begin
      // first order average of the rectified line once per period
      next_vavg = vavg;
      if (avg_step)
         next_vavg = q15_t'(wide_t'(vavg) + ((wide_t'(rectified_line_voltage) - wide_t'(vavg)) >>> `AVG_SHIFT));  // see [R9]
      // reference = amplitude * line / peak, peak = pi/2 * average
      vm        = (wide_t'(vavg) * `HALF_PI_Q15) >>> `Q15_FRAC;
      shape_num = wide_t'(volt_if.out) * wide_t'(rectified_line_voltage);
      next_iref = (vm > 0) ? sat_q15(shape_num / vm, '0, wide_t'(`Q15_ONE)) : '0;  // see [R11]
      // main duty from line, inductor command and bus
      drop      = (wide_t'(rectified_line_voltage) - wide_t'(cur_if.out)) <<< `Q15_FRAC;
      next_main = duty_main;
      if (dec_step)
      begin
         if (bus_voltage_sample > 0)
            next_main = sat_q15(wide_t'(`Q15_ONE) - drop / wide_t'(bus_voltage_sample),
                                '0, wide_t'(`Q15_ONE));  // see [R15] see [R13] see [R8]
         else
            next_main = '0;
      end
      // per phase duties
      next_duty_one = duty_one;
      next_duty_two = duty_two;
      if (split_step)
      begin
         next_duty_one = sat_q15(wide_t'(duty_main) + wide_t'(bal_if.out), '0, wide_t'(`Q15_ONE));  // see [R6] see [R16]
         next_duty_two = sat_q15(wide_t'(duty_main) - wide_t'(bal_if.out), '0, wide_t'(`Q15_ONE));  // see [R6] see [R16]
      end
      // phase two runs half a period behind phase one
      ph_two      = (sw_cnt >= SW_HALF) ? sw_cnt - SW_HALF : sw_cnt + SW_HALF;  // see [R14]
      // on-times latched at each phase's period start
      next_on_one = (sw_cnt == '0) ? q15_t'((wide_t'(duty_one) * `SW_CYCLES) >>> `Q15_FRAC) : on_one;
      next_on_two = (ph_two == '0) ? q15_t'((wide_t'(duty_two) * `SW_CYCLES) >>> `Q15_FRAC) : on_two;
      next_pwm_one = (wide_t'(sw_cnt) < wide_t'(on_one));  // see [R12]
      next_pwm_two = (wide_t'(ph_two) < wide_t'(on_two));  // see [R12] see [R14]
   end

   // register arithmetic results and outputs
   always_ff @(posedge clk_sys)
   begin
      if (reset)
      begin
         dec_step               <= 1'b0;
         split_step             <= 1'b0;
         vavg                   <= '0;
         line_current_reference <= '0;
         duty_main              <= '0;
         duty_one               <= '0;
         duty_two               <= '0;
         on_one                 <= '0;
         on_two                 <= '0;
         pwm_one                <= 1'b0;
         pwm_two                <= 1'b0;
      end
      else
      begin
         dec_step               <= cur_step;
         split_step             <= dec_step;
         vavg                   <= next_vavg;
         line_current_reference <= next_iref;
         duty_main              <= next_main;
         duty_one               <= next_duty_one;
         duty_two               <= next_duty_two;
         on_one                 <= next_on_one;
         on_two                 <= next_on_two;
         pwm_one                <= next_pwm_one;
         pwm_two                <= next_pwm_two;
      end
   end

   // checks
   sequence s_dec_chain;
      cur_step ##1 dec_step ##1 split_step;
   endsequence
   property p_chain;
      @(posedge clk_sys) disable iff (reset)
      cur_step |-> s_dec_chain;
   endproperty
   a_chain: assert property (p_chain) else $error("decoupling chain broken"); // see [R8]

   property p_cur_rate;
      @(posedge clk_sys) disable iff (reset)
      cur_step |=> !cur_step [*8];
   endproperty
   a_cur_rate: assert property (p_cur_rate) else $error("current loop stepped too soon"); // see [R4]

   property p_cur_period;
      @(posedge clk_sys) disable iff (reset)
      (cur_cnt == CUR_LAST) |=> cur_step && (sw_cnt == '0);
   endproperty
   a_cur_period: assert property (p_cur_period) else $error("current loop not aligned to period"); // see [R4]

   property p_avg_rate;
      @(posedge clk_sys) disable iff (reset)
      avg_step |-> (sw_cnt == '0) ##1 !avg_step;
   endproperty
   a_avg_rate: assert property (p_avg_rate) else $error("average update misplaced"); // see [R9]

   property p_volt_period;
      @(posedge clk_sys) disable iff (reset)
      (volt_cnt == VOLT_LAST) |=> volt_step ##1 !volt_step;
   endproperty
   a_volt_period: assert property (p_volt_period) else $error("voltage loop period wrong"); // see [R2]

   property p_bal_period;
      @(posedge clk_sys) disable iff (reset)
      (bal_cnt == BAL_LAST) |=> bal_step ##1 !bal_step;
   endproperty
   a_bal_period: assert property (p_bal_period) else $error("balance loop period wrong"); // see [R7]

   property p_split;
      @(posedge clk_sys) disable iff (reset)
      (split_step && (duty_main > `BAL_LIMIT) && (duty_main < `Q15_ONE - `BAL_LIMIT))
      |=> (wide_t'(duty_one) + wide_t'(duty_two) == 2 * wide_t'($past(duty_main)))
          && (duty_one - duty_two == 2 * $past(bal_if.out));
   endproperty
   a_split: assert property (p_split) else $error("phase duties not symmetric"); // see [R6]

   property p_phase;
      @(posedge clk_sys) disable iff (reset)
      (sw_cnt == '0) |-> (ph_two == SW_HALF);
   endproperty
   a_phase: assert property (p_phase) else $error("phases not half a period apart"); // see [R14]

   property p_pwm_width;
      @(posedge clk_sys) disable iff (reset)
      pwm_one |-> (wide_t'($past(sw_cnt)) < wide_t'($past(on_one)));
   endproperty
   a_pwm_width: assert property (p_pwm_width) else $error("phase one on beyond its on-time"); // see [R12]

   property p_main_hold;
      @(posedge clk_sys) disable iff (reset)
      !dec_step |=> $stable(duty_main);
   endproperty
   a_main_hold: assert property (p_main_hold) else $error("main duty moved off its step"); // see [R15]
endmodule : pfc_control
`default_nettype wire

// ---- verif/boost_stage_model.sv ----
// behavioural two phase boost stage: converter samples out, gate pulses in
// assumes the bench sets the sampled levels through apply on clk_sys
`timescale 1ns/100ps
`default_nettype none
module boost_stage_model
   import pfc_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic pwm_one,
   input  wire logic pwm_two,
   output var  q15_t bus_voltage_sample,
   output var  q15_t line_current_sample,
   output var  q15_t rectified_line_voltage,
   output var  q15_t switch_one_current,
   output var  q15_t switch_two_current
);
   int unsigned cyc      = 0;     // free running cycle count
   int unsigned rise_one = 0;     // cycle of the last phase one turn-on
   int unsigned rise_two = 0;     // cycle of the last phase two turn-on
   int unsigned high_one = 0;     // length of the running phase one pulse
   int unsigned on_one   = 0;     // length of the last whole phase one pulse
   logic        last_one = 1'b0;  // gate levels one cycle back
   logic        last_two = 1'b0;

   // gate pulse timing, measured at the switch inputs
   always_ff @(posedge clk_sys)
   begin
      cyc      <= cyc + 1;
      last_one <= pwm_one;
      last_two <= pwm_two;
      if (pwm_one && !last_one)
      begin
         rise_one <= cyc;
         on_one   <= high_one;
         high_one <= 1;
      end
      else if (pwm_one)
         high_one <= high_one + 1;
      if (pwm_two && !last_two)
         rise_two <= cyc;
   end

   // new converter state, sampled levels held until the next call
   task automatic apply(input q15_t vdc, input q15_t vac, input q15_t iac, input q15_t i1, input q15_t i2);
      bus_voltage_sample     <= vdc;
      rectified_line_voltage <= vac;
      line_current_sample    <= iac;
      switch_one_current     <= i1;
      switch_two_current     <= i2;
   endtask : apply
endmodule : boost_stage_model
`default_nettype wire

// ---- verif/pfc_control_bench.sv ----
// self-checking bench for the interleaved boost controller
// assumes the design files and pfc_cfg.svh are compiled before it
`timescale 1ns/100ps
`default_nettype none
`include "pfc_cfg.svh"
module pfc_control_bench;
   import pfc_pkg::*;
   localparam int SETTLE = `CUR_CYCLES + 100;  // one current chain plus balance step
   localparam int LIMIT  = 60000;              // cycle ceiling for the run
   logic  clk_sys = 1'b0;
   logic  reset   = 1'b1;
   q15_t  bus_voltage_setpoint = '0;
   gain_t volt_kp = '0, volt_ki = '0, cur_kp = '0, cur_ki = '0, bal_kp = '0, bal_ki = '0;
   q15_t  bus_voltage_sample, line_current_sample, rectified_line_voltage;
   q15_t  switch_one_current, switch_two_current;
   q15_t  line_current_reference, duty_one, duty_two;
   logic  pwm_one, pwm_two;
   int    error_cnt  = 0;  // mismatches seen
   int    n_compared = 0;  // comparisons made
   int    tick       = 0;  // cycles since start

   pfc_control #(.VOLT_CYCLES(100), .BAL_CYCLES(60)) dut (.clk_sys(clk_sys), .reset(reset),
      .bus_voltage_setpoint(bus_voltage_setpoint), .bus_voltage_sample(bus_voltage_sample),
      .line_current_sample(line_current_sample), .rectified_line_voltage(rectified_line_voltage),
      .switch_one_current(switch_one_current), .switch_two_current(switch_two_current),
      .volt_kp(volt_kp), .volt_ki(volt_ki), .cur_kp(cur_kp), .cur_ki(cur_ki), .bal_kp(bal_kp),
      .bal_ki(bal_ki), .line_current_reference(line_current_reference), .duty_one(duty_one),
      .duty_two(duty_two), .pwm_one(pwm_one), .pwm_two(pwm_two));

   boost_stage_model plant (.clk_sys(clk_sys), .pwm_one(pwm_one), .pwm_two(pwm_two),
      .bus_voltage_sample(bus_voltage_sample), .line_current_sample(line_current_sample),
      .rectified_line_voltage(rectified_line_voltage), .switch_one_current(switch_one_current),
      .switch_two_current(switch_two_current));

   // 100 mhz control clock
   initial
   begin
      forever #5 clk_sys = ~clk_sys;
   end

   // a hang counts as a mismatch and closes the run
   always @(posedge clk_sys)
   begin
      tick = tick + 1;
      if (tick == LIMIT)
      begin
         error_cnt = error_cnt + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (error_cnt == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // compare within a tolerance, unknown never matches
   task automatic check(input string what, input int exp, input q15_t got, input int tol);
      int d;
      d = int'(got) - exp;
      n_compared = n_compared + 1;
      if ($isunknown(got) || d > tol || d < -tol)
      begin
         error_cnt = error_cnt + 1;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check

   // got must lie strictly above lo
   task automatic check_gt(input string what, input int lo, input q15_t got);
      n_compared = n_compared + 1;
      if ($isunknown(got) || int'(got) <= lo)
      begin
         error_cnt = error_cnt + 1;
         $display("mismatch %s expected above %0d seen %0d", what, lo, got);
      end
   endtask : check_gt

   // main duty from decoupling with a given inductor voltage command
   function automatic int exp_duty(input int vac, input int vdc, input int vl);
      int x;
      if (vdc <= 0)
         return 0;
      x = 32767 - ((vac - vl) * 32768) / vdc;
      return (x < 0) ? 0 : ((x > 32767) ? 32767 : x);
   endfunction : exp_duty

   task automatic drive(input q15_t vdc, input q15_t vac, input q15_t iac, input q15_t i1, input q15_t i2);
      @(posedge clk_sys);
      plant.apply(vdc, vac, iac, i1, i2);
   endtask : drive

   task automatic wait_settled(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : wait_settled

   // outputs held at zero in reset, then released
   task automatic t_reset();
      drive(16'sh4000, 16'sh2000, '0, '0, '0);
      wait_settled(2);
      check("duty_one", 0, duty_one, 0);
      check("duty_two", 0, duty_two, 0);
      check("reference", 0, line_current_reference, 0);
      check("pwm", 0, {14'h0, pwm_one, pwm_two}, 0);
      @(posedge clk_sys);
      reset <= 1'b0;
   endtask : t_reset

   // decoupled duty across its range, with clamps and a dead bus
   task automatic t_decouple();
      q15_t vac_tab [5] = '{16'sh2000, 16'sh0000, 16'sh4e20, 16'sh2000, 16'sh2000};
      q15_t vdc_tab [5] = '{16'sh4000, 16'sh4000, 16'sh4000, 16'sh0000, -16'sh0064};
      for (int k = 0; k < 5; k++)
      begin
         drive(vdc_tab[k], vac_tab[k], '0, '0, '0);
         wait_settled(SETTLE);
         check("duty_one", exp_duty(vac_tab[k], vdc_tab[k], 0), duty_one, 1);
         check("duty_two", exp_duty(vac_tab[k], vdc_tab[k], 0), duty_two, 1);
      end
   endtask : t_decouple

   // duty follows a line step only at the current loop rate
   task automatic t_rate();
      q15_t prev;
      int   n;
      drive(16'sh4000, 16'sh1000, '0, '0, '0);
      wait_settled(SETTLE);
      prev = duty_one;
      drive(16'sh4000, 16'sh3000, '0, '0, '0);
      n = 0;
      while (duty_one === prev && n < `CUR_CYCLES + 10)
      begin
         wait_settled(1);
         n = n + 1;
      end
      check("duty step", exp_duty(16'sh3000, 16'sh4000, 0), duty_one, 1);
      prev = duty_one;
      drive(16'sh4000, 16'sh1000, '0, '0, '0);
      n = 1;
      while (duty_one === prev && n < `CUR_CYCLES + 10)
      begin
         wait_settled(1);
         n = n + 1;
      end
      check("duty update spacing", `CUR_CYCLES, q15_t'(n), 4);
   endtask : t_rate

   // balance correction added to phase one, taken from phase two, clamped
   task automatic t_balance();
      int d;
      d = exp_duty(16'sh2000, 16'sh4000, 0);
      drive(16'sh4000, 16'sh2000, '0, 16'sh1770, 16'sh1388);
      bal_kp <= 16'sh1000;
      wait_settled(SETTLE);
      check("duty_one", d - 1000, duty_one, 1);
      check("duty_two", d + 1000, duty_two, 1);
      // clamped with a live integral term, which must stay frozen
      drive(16'sh4000, 16'sh2000, '0, 16'sh3a98, 16'sh1388);
      bal_ki <= 16'sh0100;
      wait_settled(SETTLE);
      check("duty_one", d - `BAL_LIMIT, duty_one, 1);
      check("duty_two", d + `BAL_LIMIT, duty_two, 1);
      // integral term alone walks the correction out to its clamp
      drive(16'sh4000, 16'sh2000, '0, 16'sh1770, 16'sh1388);
      bal_kp <= '0;
      wait_settled(3 * SETTLE);
      check("duty_one integral", d - `BAL_LIMIT, duty_one, 1);
      // reset in mid-run clears the held integral and the duties
      @(posedge clk_sys);
      bal_ki <= '0;
      reset  <= 1'b1;
      wait_settled(4);
      check("duty_one after reset", 0, duty_one, 0);
      @(posedge clk_sys);
      reset <= 1'b0;
   endtask : t_balance

   // on-time within the fixed period, second phase half a period behind
   task automatic t_pwm();
      q15_t vac_tab [2] = '{16'sh2000, 16'sh1000};
      int   d;
      for (int k = 0; k < 2; k++)
      begin
         d = exp_duty(vac_tab[k], 16'sh4000, 0);
         drive(16'sh4000, vac_tab[k], '0, '0, '0);
         wait_settled(SETTLE + 3 * `SW_CYCLES);
         check("pwm on-time", d * `SW_CYCLES / 32768, q15_t'(plant.on_one), 1);
         // either phase may have risen last, so add a period before the modulo
         d = int'((plant.rise_two + `SW_CYCLES - plant.rise_one) % `SW_CYCLES);
         check("phase offset", `SW_CYCLES / 2, q15_t'(d), 1);
      end
   endtask : t_pwm

   // voltage loop sets reference amplitude, line shape gates it, current loop moves duty
   task automatic t_loops();
      drive(16'sh4000, 16'sh2000, '0, '0, '0);
      volt_kp <= 16'sh1000;
      bus_voltage_setpoint <= 16'sh4e20;
      wait_settled(SETTLE);
      check_gt("reference", 0, line_current_reference);
      drive(16'sh4000, 16'sh0000, '0, '0, '0);
      wait_settled(300);
      check("reference at line zero", 0, line_current_reference, 0);
      drive(16'sh4000, 16'sh2000, '0, '0, '0);
      cur_kp <= 16'sh1000;
      wait_settled(SETTLE);
      check_gt("duty with current demand", exp_duty(16'sh2000, 16'sh4000, 0), duty_one);
      @(posedge clk_sys);
      bus_voltage_setpoint <= 16'sh2000;
      wait_settled(300);
      check("reference with bus high", 0, line_current_reference, 0);
   endtask : t_loops

   initial
   begin
      t_reset();
      t_decouple();
      t_rate();
      t_balance();
      t_pwm();
      t_loops();
      print_verdict();
   end
endmodule : pfc_control_bench
`default_nettype wire
